//--- verilog/rtv_top.sv
/*
 Time, date, alarm time and alarm date value registers behind an AXI4-Lite slave.
 Assumes a single-clock system; counting and alarm matching live elsewhere, the write-enable unlock lives here.
*/
// What this block does
// - Seconds tens digit at bits 15-12, BCD 0-5, top bit reads zero.
// - Seconds units digit at bits 11-8, BCD 0-9.
// - Weekday digit at bits 3-0 of date registers, 0-6, bit 3 zero.
// - Day units digit at bits 11-8 of date registers, BCD 0-9.
// - Current date register takes writes only while clock write enable is 1.
// - Date bits 7-4 reserved; software writes zero, ignores read value.
`timescale 1ns/10ps
module rtv_top (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic [4:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [4:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic CLOCK_SYNC_STATUS,
	input wire logic ALARM_SYNC_STATUS,
	output logic CLOCK_WRITE_ENABLE
);
	import rtv_pkg::*;
	`include "rtv_defs.svh"

	////////////////////////////////////////////////////////////////////////////
	// Write channel capture: address and data taken in either order
	rtv_addr_type aw_q;
	rtv_wdata_type w_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic awready_q;
	logic wready_q;
	logic wr_fire;
	logic wr_known;
	logic wen_time, wen_date, wen_atime, wen_adate;
	logic wren_q;

	assign wr_fire = aw_q.valid && w_q.valid && !bvalid_q;
	assign wr_known = aw_q.addr[1:0] == 2'h0 && aw_q.addr <= `RTV_OFS_CTRL;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			aw_q <= '0;
			awready_q <= 1'b1;
		end else if (S_AXI_AWVALID && awready_q) begin
			aw_q <= '{addr: S_AXI_AWADDR, valid: 1'b1};
			awready_q <= 1'b0;
		end else if (wr_fire) begin
			aw_q.valid <= 1'b0;
		end else if (!aw_q.valid && !bvalid_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			w_q <= '0;
			wready_q <= 1'b1;
		end else if (S_AXI_WVALID && wready_q) begin
			w_q <= '{data: S_AXI_WDATA, strb: S_AXI_WSTRB, valid: 1'b1};
			wready_q <= 1'b0;
		end else if (wr_fire) begin
			w_q.valid <= 1'b0;
		end else if (!w_q.valid && !bvalid_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			bvalid_q <= 1'b0;
			bresp_q <= RTV_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_known ? RTV_OKAY : RTV_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register decode
	// One select per register, raised only in the cycle the write retires
	always_comb begin
		wen_time = 1'b0;
		wen_date = 1'b0;
		wen_atime = 1'b0;
		wen_adate = 1'b0;
		if (wr_fire) begin
			unique case (aw_q.addr)
				{1'b0, `RTV_OFS_TIME}: wen_time = 1'b1;
				// Date write blocked unless the write enable is set; bus still answers OKAY
				{1'b0, `RTV_OFS_DATE}: wen_date = wren_q;
				{1'b0, `RTV_OFS_ATIME}: wen_atime = 1'b1;
				{1'b0, `RTV_OFS_ADATE}: wen_adate = 1'b1;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			wren_q <= 1'b0;
		end else if (wr_fire && aw_q.addr == `RTV_OFS_CTRL && w_q.strb[0]) begin
			wren_q <= w_q.data[`RTV_CTRL_WREN];
		end
	end

	logic [31:0] time_q, date_q, atime_q, adate_q;

	// Seconds digits and tens top bit via mask
	rtv_value_reg #(.WMASK(`RTV_MASK_TIME)) u_time (
		.clk(CLOCK),
		.rst_n(RSTN),
		.wr_en(wen_time),
		.wr_data(w_q.data),
		.wr_strb(w_q.strb),
		.value_q(time_q)
	);

	// Reserved bits 7-4 and weekday bit 3 held at zero
	rtv_value_reg #(.WMASK(`RTV_MASK_DATE)) u_date (
		.clk(CLOCK),
		.rst_n(RSTN),
		.wr_en(wen_date),
		.wr_data(w_q.data),
		.wr_strb(w_q.strb),
		.value_q(date_q)
	);

	rtv_value_reg #(.WMASK(`RTV_MASK_TIME)) u_atime (
		.clk(CLOCK),
		.rst_n(RSTN),
		.wr_en(wen_atime),
		.wr_data(w_q.data),
		.wr_strb(w_q.strb),
		.value_q(atime_q)
	);

	rtv_value_reg #(.WMASK(`RTV_MASK_ADATE)) u_adate (
		.clk(CLOCK),
		.rst_n(RSTN),
		.wr_en(wen_adate),
		.wr_data(w_q.data),
		.wr_strb(w_q.strb),
		.value_q(adate_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read channel: one-cycle answer from registered data
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_d;
	logic rknown_d;
	logic [31:0] ctrl_word;

	// Control word built from the field positions; unlisted bits read zero
	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[`RTV_CTRL_WREN] = wren_q;
		ctrl_word[`RTV_CTRL_CSYNC] = CLOCK_SYNC_STATUS;
		ctrl_word[`RTV_CTRL_ASYNC] = ALARM_SYNC_STATUS;
	end

	always_comb begin
		rdata_d = 32'h00000000;
		rknown_d = 1'b1;
		unique case (S_AXI_ARADDR)
			{1'b0, `RTV_OFS_TIME}: rdata_d = time_q;
			{1'b0, `RTV_OFS_DATE}: rdata_d = date_q;
			{1'b0, `RTV_OFS_ATIME}: rdata_d = atime_q;
			{1'b0, `RTV_OFS_ADATE}: rdata_d = adate_q;
			// Sync flags are mirrored so software can poll before writing
			`RTV_OFS_CTRL: rdata_d = ctrl_word;
			default: rknown_d = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RTV_OKAY;
		end else if (S_AXI_ARVALID && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rdata_d;
			rresp_q <= rknown_d ? RTV_OKAY : RTV_SLVERR;
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY = wready_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign CLOCK_WRITE_ENABLE = wren_q;
endmodule : rtv_top

//--- shared/rtv_defs.svh
/*
 Register offsets, field positions, writable-bit masks and a control register layout for
 the time/date/alarm value register block. Assumes inclusion by bare name.
*/
`ifndef RTV_DEFS_SVH
`define RTV_DEFS_SVH

`define RTV_OFS_TIME 4'h0
`define RTV_OFS_DATE 4'h4
`define RTV_OFS_ATIME 4'h8
`define RTV_OFS_ADATE 4'hC
`define RTV_OFS_CTRL 5'h10

// Writable masks: hour tens 2 bits, minute/second tens 3 bits, units 4 bits
`define RTV_MASK_TIME 32'h3F7F7F00
// Year 8 bits (none in alarm date), month tens 1 bit, day tens 2 bits, weekday 3 bits
`define RTV_MASK_DATE 32'hFF1F3F07
`define RTV_MASK_ADATE 32'h001F3F07

`define RTV_SEC_TENS_HI 15
`define RTV_SEC_TENS_LO 12
`define RTV_SEC_UNITS_HI 11
`define RTV_SEC_UNITS_LO 8
`define RTV_DAY_UNITS_HI 11
`define RTV_DAY_UNITS_LO 8
`define RTV_WDAY_HI 3
`define RTV_WDAY_LO 0

`define RTV_CTRL_WREN 0
`define RTV_CTRL_CSYNC 1
`define RTV_CTRL_ASYNC 2

`define RTV_RESET_VALUE 32'h00000000

`endif

//--- shared/rtv_pkg.sv
/*
 Types for the value register block: AXI4-Lite channel bundles and response codes.
 Assumes a 32-bit AXI4-Lite master.
*/
package rtv_pkg;
	typedef struct packed {
		logic [4:0] addr;
		logic valid;
	} rtv_addr_type;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] strb;
		logic valid;
	} rtv_wdata_type;

	typedef enum logic [1:0] {
		RTV_OKAY = 2'h0,
		RTV_SLVERR = 2'h2
	} rtv_resp_type;
endpackage : rtv_pkg

//--- verilog/rtv_value_reg.sv
/*
 One 32-bit value register with byte strobes and a fixed writable-bit mask.
 Assumes the caller qualifies the write enable.
*/
`timescale 1ns/10ps
module rtv_value_reg #(
	parameter logic [31:0] WMASK = 32'hFFFFFFFF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	output logic [31:0] value_q
);
	import rtv_pkg::*;
	`include "rtv_defs.svh"

	logic [31:0] lane_mask;
	logic [31:0] value_d;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_mask[i*8 +: 8] = {8{wr_strb[i]}};
		end
		// Read-only-zero digit bits never take write data
		value_d = (value_q & ~(lane_mask & WMASK)) | (wr_data & lane_mask & WMASK);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= `RTV_RESET_VALUE;
		end else if (wr_en) begin
			value_q <= value_d;
		end
	end
endmodule : rtv_value_reg

//--- dv/rtv_top_monitor.sv
/*
 Checker for read data and handshakes of the value register block.
 Assumes it is bound into rtv_top and sees only its ports.
*/
`timescale 1ns/10ps
module rtv_top_monitor (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic [4:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic CLOCK_WRITE_ENABLE
);
	logic [4:0] ra_q;
	logic tm;
	logic dt;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	////////////////////////////////
	// Read address kept, data belongs to the taken address
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			ra_q <= 5'h00;
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
			ra_q <= S_AXI_ARADDR;
	end
	assign tm = S_AXI_RVALID && !ra_q[4] && !ra_q[2];
	assign dt = S_AXI_RVALID && !ra_q[4] && ra_q[2];
	AST_SEC_TENS_MSB: assert property (tm |-> !S_AXI_RDATA[15])
		else $error("seconds tens top bit set");
	AST_TIME_ZERO_BITS: assert property (tm |-> (S_AXI_RDATA & 32'hC08080FF) == 32'h0)
		else $error("time zero bits set");
	AST_WDAY_MSB: assert property (dt |-> !S_AXI_RDATA[3])
		else $error("weekday top bit set");
	AST_DATE_RSVD: assert property (dt |-> S_AXI_RDATA[7:4] == 4'h0)
		else $error("date reserved bits set");
	AST_DAY_TENS: assert property (dt |-> S_AXI_RDATA[15:14] == 2'h0)
		else $error("day tens top bits set");
	AST_WEN_MOVE: assert property ($changed(CLOCK_WRITE_ENABLE) |-> $rose(S_AXI_BVALID))
		else $error("write enable moved without a write");
	AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_B_RETIRE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response held");
endmodule : rtv_top_monitor

bind rtv_top rtv_top_monitor i_rtv_top_monitor (
	.CLOCK(CLOCK),
	.RSTN(RSTN),
	.S_AXI_ARADDR(S_AXI_ARADDR),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.CLOCK_WRITE_ENABLE(CLOCK_WRITE_ENABLE)
);

//--- dv/rtv_time_date_alarm_values_tb_top.sv
/*
 Self-checking bench for the value register block.
 Assumes rtv_top with its bound monitor; bench names match the ports.
*/
`timescale 1ns/10ps
module rtc_time_date_alarm_values_tb_top;
	logic CLOCK;
	logic RSTN = 1'b0;
	logic [4:0] S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00, a;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
	logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	logic CLOCK_SYNC_STATUS = 1'b0, ALARM_SYNC_STATUS = 1'b0;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdat, v;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic CLOCK_WRITE_ENABLE;
	logic [31:0] model [4] = '{default: 32'h0};
	int seed = 72568;
	int fails = 0;
	int comparisons = 0;
	rtv_top i_rtv_top (
		.CLOCK(CLOCK),
		.RSTN(RSTN),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY),
		.CLOCK_SYNC_STATUS(CLOCK_SYNC_STATUS),
		.ALARM_SYNC_STATUS(ALARM_SYNC_STATUS),
		.CLOCK_WRITE_ENABLE(CLOCK_WRITE_ENABLE)
	);
	////////////////////////////////
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	function automatic logic [31:0] msk(input logic [4:0] x);
		case (x)
			5'h04: return 32'hFF1F3F07;
			5'h0C: return 32'h001F3F07;
			default: return 32'h3F7F7F00;
		endcase
	endfunction : msk
	// Leading edge keeps a new request off the edge that ended the last one
	task automatic wr(input logic [4:0] ad, input logic [31:0] d, input logic [3:0] s);
		@(posedge CLOCK);
		S_AXI_AWADDR <= ad;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= s;
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1);
		resp = S_AXI_BRESP;
		S_AXI_BREADY <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] ad);
		@(posedge CLOCK);
		S_AXI_ARADDR <= ad;
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge CLOCK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1);
		rdat = S_AXI_RDATA;
		resp = S_AXI_RRESP;
		S_AXI_RREADY <= 1'b0;
	endtask : rd
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge CLOCK);
		fails++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge CLOCK);
		RSTN <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			rd(5'(i * 4));
			chk(rdat, 32'h0);
		end
		$display("reset values done");
		wr(5'h10, 32'h1, 4'hF);
		chk({31'h0, CLOCK_WRITE_ENABLE}, 32'h1);
		// Hardware does not police the sync flags; busy shows only on the side not written
		for (int i = 0; i < 24; i++) begin
			a = 5'(($random(seed) & 3) * 4);
			v = 32'($random(seed)) & 32'hFFFFFF0F;
			CLOCK_SYNC_STATUS <= 1'($random(seed)) & a[3];
			ALARM_SYNC_STATUS <= 1'($random(seed)) & ~a[3];
			wr(a, v, 4'hF);
			model[a[3:2]] = v & msk(a);
			rd(a);
			chk(rdat, model[a[3:2]]);
			rd(5'h10);
			chk(rdat, {29'h0, ALARM_SYNC_STATUS, CLOCK_SYNC_STATUS, 1'b1});
		end
		$display("random values done");
		CLOCK_SYNC_STATUS <= 1'b0;
		ALARM_SYNC_STATUS <= 1'b0;
		wr(5'h10, 32'h0, 4'hF);
		wr(5'h04, 32'h99123106, 4'hF);
		chk({30'h0, resp}, 32'h0);
		rd(5'h04);
		chk(rdat, model[1]);
		wr(5'h00, 32'h23595900, 4'hF);
		wr(5'h00, 32'hFFFFFFFF, 4'h2);
		rd(5'h00);
		chk(rdat, 32'h23597F00);
		$display("lock and strobe done");
		wr(5'h14, 32'hFFFFFFFF, 4'hF);
		chk({30'h0, resp}, 32'h2);
		rd(5'h14);
		chk(rdat, 32'h0);
		chk({30'h0, resp}, 32'h2);
		$display("unmapped done");
		conclude();
	end
endmodule : rtc_time_date_alarm_values_tb_top
